// *** cpu_port_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module cpu_port_model (
  // Clock
  input wire logic core_clk,
  // Port pins toward the device
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic a0,
  output logic [7:0] data_in,
  // Read data back
  input wire logic [7:0] data_out
);
  ////////////////////////////////////////
  // Strobes rest high until the first cycle.
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    a0 = 1'b0;
    data_in = 8'h00;
  end
  // One strobe cycle; the released bus shows inverted data, not stale.
  task automatic cyc(input logic sel, input logic rd, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge core_clk);
    cs_n <= 1'b0;
    a0 <= sel;
    data_in <= d;
    if (rd) rd_n <= 1'b0;
    else wr_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    q = data_out;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    data_in <= ~d;
    repeat (5) @(posedge core_clk);
  endtask
  // Pointer first, then the access.
  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [7:0] q;
    cyc(1'b0, 1'b0, adr, q);
    cyc(1'b1, 1'b0, (adr == 8'h05) ? (d & 8'h7F) : d, q);
  endtask
  task automatic rd(input logic [7:0] adr, output logic [7:0] q);
    cyc(1'b0, 1'b0, adr, q);
    cyc(1'b1, 1'b1, 8'hA5, q);
  endtask
  // Low byte first, because the high byte launches a transfer.
  task automatic dma(input logic [7:0] lo, input logic [7:0] hi);
    wr(8'h35, lo);
    wr(8'h36, hi);
  endtask
endmodule
`default_nettype wire

// *** ctrl_regs_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module ctrl_regs_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Outputs and inputs watched
  input wire logic bus_transceiver_low_power,
  input wire logic suspend,
  input wire logic line_force_oe,
  input wire logic line_dp,
  input wire logic line_dm,
  input wire logic usb_enable,
  input wire logic dma_enable,
  input wire logic dma_start,
  input wire logic dma_active,
  input wire logic dma_done_evt,
  input wire logic token_valid,
  input wire logic token_accept
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // A start is a single-cycle pulse.
  sequence start_pulse;
    dma_start ##1 !dma_start;
  endsequence
  chk_suspend_mode: assert property (
    suspend == (bus_transceiver_low_power && !usb_enable))
    else $error("suspend does not follow standby and enable");
  chk_force_lines: assert property (
    line_force_oe |-> !(line_dp && line_dm))
    else $error("both lines forced high");
  chk_reset_clear: assert property (
    $past(reset) |-> !line_force_oe && !usb_enable && !dma_enable)
    else $error("outputs not clear after reset");
  chk_start_enable: assert property (
    dma_start |-> dma_enable)
    else $error("start while disabled");
  chk_start_active: assert property (
    dma_start |-> dma_active)
    else $error("start without activity");
  chk_start_single: assert property (
    dma_start |-> start_pulse)
    else $error("start longer than one cycle");
  chk_done_idle: assert property (
    dma_done_evt |=> !dma_active || dma_start)
    else $error("activity stays after done");
  chk_token_cause: assert property (
    token_accept |-> $past(token_valid))
    else $error("accept without a token");
endmodule
`default_nettype wire

// *** pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 12,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Asynchronous inputs and their synchronised copies
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  // Two flops per bit; the first stage feeds only the second.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        meta_q[i] <= IDLE[i];
        stable_q[i] <= IDLE[i];
      end else if (clk_en) begin
        meta_q[i] <= async_in[i];
        stable_q[i] <= meta_q[i];
      end
    end
  end

  assign sync_out = stable_q;

endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic core_clk, reset, clk_en, cs_n, rd_n, wr_n, a0, data_oe, token_valid;
  logic token_accept, bus_transceiver_low_power, suspend, bus_speed_select;
  logic line_force_oe, line_dp, line_dm, usb_enable, dma_read_dir;
  logic dma_enable, dma_start, dma_active, interrupt_request_out;
  logic [7:0] data_in, data_out, q;
  logic [6:0] ev, token_addr;
  logic [15:0] dma_total_count;
  int n_fail, num_checks, m_mask, m_stat, seed, v, a, k, n_start, n_oe;
  wire logic [8:0] pins = {bus_transceiver_low_power, suspend,
    bus_speed_select, line_force_oe, line_dp, line_dm, usb_enable,
    dma_read_dir, dma_enable};
  ////////////////////////////////////////
  usb_periph_control_regs dut (.core_clk, .reset, .clk_en, .cs_n,
    .rd_n, .wr_n, .a0, .data_in, .data_out, .data_oe,
    .bus_reset_evt(ev[6]), .sof_evt(ev[5]), .dma_done_evt(ev[4]),
    .ep_done_evt(ev[3:0]), .token_valid, .token_addr, .token_accept,
    .bus_transceiver_low_power, .suspend, .bus_speed_select, .line_force_oe,
    .line_dp, .line_dm, .usb_enable, .dma_read_dir, .dma_enable, .dma_start,
    .dma_active, .dma_total_count, .interrupt_request_out);
  cpu_port_model cpu (.core_clk, .cs_n, .rd_n, .wr_n, .a0, .data_in,
    .data_out);
  // Clock, and a start counter that exposes missed or extra pulses.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (dma_start === 1'b1) n_start++;
  // Output-enable cycles are counted for every read.
  always @(posedge core_clk) if (data_oe === 1'b1) n_oe++;
  task automatic cmp_pin(string s, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic cmp_reg(string s, logic [7:0] e, logic [7:0] g);
    cmp_pin(s, {8'h00, e}, {8'h00, g});
  endtask
  // The model holds a read strobe five cycles, so output enable stands five.
  task automatic rchk(logic [7:0] adr, logic [7:0] e);
    n_oe = 0;
    cpu.rd(adr, q);
    cmp_reg("reg read", e, q);
    cmp_pin("oe cycles", 16'h0005, 16'(n_oe));
  endtask
  task automatic chk_ctrl(logic [7:0] c);
    logic [15:0] e;
    e = {7'h00, c[6], c[6] & ~c[0], c[5], |c[4:3], c[4] & c[3],
         c[4] & ~c[3], c[0], c[2], c[1]};
    cmp_pin("ctrl hi", e >> 6, 16'(pins[8:6]));
    cmp_pin("ctrl lo", e & 16'h3F, 16'(pins[5:0]));
  endtask
  // Events are one-cycle pulses; the output follows the masked status.
  task automatic pulse(int j);
    logic [15:0] e;
    @(posedge core_clk);
    ev <= 7'(1 << j);
    @(posedge core_clk);
    ev <= 7'h00;
    m_stat = m_stat | (1 << j);
    e = 16'(|(m_stat & m_mask));
    repeat (2) @(posedge core_clk);
    #1 cmp_pin("irq", e, 16'(interrupt_request_out));
  endtask
  // The accept pulse stands for the one cycle after the token.
  task automatic tok(logic [6:0] t, logic e);
    @(posedge core_clk);
    token_valid <= 1'b1;
    token_addr <= t;
    @(posedge core_clk);
    token_valid <= 1'b0;
    #1 cmp_pin("accept", 16'(e), 16'(token_accept));
    @(posedge core_clk);
    #1 cmp_pin("accept end", 16'h0000, 16'(token_accept));
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // A hang is cut short and counted as a failure.
  initial begin
    repeat (30000) @(posedge core_clk);
    n_fail++;
    final_report;
  end
  // Main sequence.
  initial begin
    seed = 32'h875d;
    reset = 1'b1;
    ev = 7'h00;
    clk_en = 1'b1;
    token_valid = 1'b0;
    token_addr = 7'h00;
    m_stat = 0;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    chk_ctrl(8'h00);
    for (k = 5; k < 8; k++) rchk(8'(k), 8'h00);
    for (k = 0; k < 8; k++) begin
      v = ($random(seed) & 32'h67) | ((k % 4) << 3);
      cpu.wr(8'h05, 8'(v));
      chk_ctrl(8'(v));
      rchk(8'h05, 8'(v));
    end
    // A write made while the clock enable is low must be lost entirely.
    clk_en <= 1'b0;
    cpu.wr(8'h05, 8'h40);
    clk_en <= 1'b1;
    chk_ctrl(8'(v));
    rchk(8'h05, 8'(v));
    a = $random(seed) & 32'h7F;
    cpu.wr(8'h07, 8'(a));
    rchk(8'h07, 8'(a));
    cpu.wr(8'h05, 8'h01);
    tok(7'(a), 1'b1);
    tok(7'(a ^ 1), 1'b0);
    cpu.wr(8'h05, 8'h00);
    tok(7'(a), 1'b0);
    for (k = 0; k < 7; k++) begin
      m_mask = 1 << k;
      cpu.wr(8'h06, 8'(m_mask));
      pulse((k + 1) % 7);
      pulse(k);
      cpu.wr(8'h06, 8'h00);
      rchk(8'h0D, 8'(m_stat));
      cpu.wr(8'h0D, 8'h7F);
      m_stat = 0;
      rchk(8'h0D, 8'h00);
    end
    cpu.wr(8'h05, 8'h01);
    n_start = 0;
    cpu.dma(8'h34, 8'h12);
    cmp_pin("no start", 16'h0000, 16'(n_start));
    cpu.wr(8'h05, 8'h07);
    v = $random(seed) & 32'hFFFF;
    cpu.dma(8'(v), 8'(v >> 8));
    cmp_pin("starts", 16'h0001, 16'(n_start));
    cmp_pin("count", 16'(v), dma_total_count);
    rchk(8'h35, 8'(v));
    rchk(8'h36, 8'(v >> 8));
    cpu.wr(8'h06, 8'hFF);
    m_mask = 8'h7F;
    rchk(8'h06, 8'hFF);
    pulse(4);
    cmp_pin("active", 16'h0000, {15'h0, dma_active});
    rchk(8'h06, 8'h7F);
    final_report;
  end
endmodule
bind usb_periph_control_regs ctrl_regs_monitor mon (.core_clk, .reset,
  .bus_transceiver_low_power, .suspend, .line_force_oe, .line_dp, .line_dm,
  .usb_enable, .dma_enable, .dma_start, .dma_active, .dma_done_evt,
  .token_valid, .token_accept);
`default_nettype wire

// *** usb_periph_control_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module usb_periph_control_regs (
  // Clock, reset and clock enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Processor data port pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic a0,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // Events from the serial engine, one-cycle pulses on core_clk
  input wire logic bus_reset_evt,
  input wire logic sof_evt,
  input wire logic dma_done_evt,
  input wire logic [usb_periph_pkg::NUM_EP-1:0] ep_done_evt,
  // Token address from the serial engine
  input wire logic token_valid,
  input wire logic [6:0] token_addr,
  output logic token_accept,
  // Transceiver and bus control
  output logic bus_transceiver_low_power,
  output logic suspend,
  output logic bus_speed_select,
  output logic line_force_oe,
  output logic line_dp,
  output logic line_dm,
  output logic usb_enable,
  // DMA control
  output logic dma_read_dir,
  output logic dma_enable,
  output logic dma_start,
  output logic dma_active,
  output logic [15:0] dma_total_count,
  // Interrupt
  output logic interrupt_request_out
);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisation.
  usb_periph_pkg::cpu_pins_s pins_raw;
  usb_periph_pkg::cpu_pins_s pins_s;
  usb_periph_pkg::cpu_pins_s pins_p_q;
  usb_periph_pkg::cpu_pins_s pins_p_d;

  // Bundled so every pin goes through the same two stages together.
  assign pins_raw = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, a0: a0,
                      data: data_in};

  // Only the second stage is read; the first may settle late.
  pin_sync #(
    .WIDTH($bits(usb_periph_pkg::cpu_pins_s)),
    .IDLE(usb_periph_pkg::PINS_IDLE)
  ) u_pin_sync (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  //////////////////////////////////////////////////////////////////////////
  // Strobe decode.
  logic wr_done;
  logic reg_wr;
  logic ptr_wr;
  logic reading;

  // A write is acted on at the end of its strobe, with data and A0 taken
  // from the cycle before, when they are known to have settled.
  // Reads have no side effects, so a long read strobe is harmless.
  assign pins_p_d = pins_s;
  assign wr_done = !pins_p_q.wr_n && !pins_p_q.cs_n && pins_s.wr_n;
  assign reg_wr = wr_done && pins_p_q.a0;
  assign ptr_wr = wr_done && !pins_p_q.a0;
  assign reading = !pins_s.cs_n && !pins_s.rd_n;

  //////////////////////////////////////////////////////////////////////////
  // Register state.
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] mask_q, mask_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] status_q, status_d;
  logic [7:0] cnt_lo_q, cnt_lo_d;
  logic [7:0] cnt_hi_q, cnt_hi_d;
  usb_periph_pkg::dma_state_e dma_q, dma_d;
  logic start_d;
  logic [7:0] events;
  logic [7:0] clear_mask;

  // Incoming event vector in status bit order.
  always_comb begin
    events = usb_periph_pkg::RST_BYTE;
    events[usb_periph_pkg::IRQ_BUS_RESET] = bus_reset_evt;
    events[usb_periph_pkg::IRQ_SOF] = sof_evt;
    events[usb_periph_pkg::IRQ_DMA_DONE] = dma_done_evt;
    events[usb_periph_pkg::IRQ_EP_TOP:0] = ep_done_evt;
  end

  // Next values for the register file and the DMA state.
  always_comb begin
    ptr_d = ptr_q;
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    addr_d = addr_q;
    cnt_lo_d = cnt_lo_q;
    cnt_hi_d = cnt_hi_q;
    dma_d = dma_q;
    start_d = 1'b0;
    clear_mask = usb_periph_pkg::RST_BYTE;
    if (ptr_wr) begin
      ptr_d = pins_p_q.data;
    end
    if (reg_wr) begin
      unique case (ptr_q)
        usb_periph_pkg::OFS_XFER_CTRL: begin
          // Bit 7 is stored as written; software keeps it zero.
          ctrl_d = pins_p_q.data;
        end
        usb_periph_pkg::OFS_IRQ_MASK: begin
          // Top bit is a live DMA view and cannot be written.
          mask_d = {1'b0, pins_p_q.data[6:0]};
        end
        usb_periph_pkg::OFS_DEV_ADDR: begin
          addr_d = pins_p_q.data;
        end
        usb_periph_pkg::OFS_IRQ_STATUS: begin
          clear_mask = pins_p_q.data;
        end
        usb_periph_pkg::OFS_DMA_CNT_LO: begin
          cnt_lo_d = pins_p_q.data;
        end
        usb_periph_pkg::OFS_DMA_CNT_HI: begin
          cnt_hi_d = pins_p_q.data;
          // The high byte write is the only trigger, and only when enabled.
          start_d = ctrl_q[usb_periph_pkg::CTL_DMA_EN];
        end
        default: begin
          // Unmapped offsets absorb the write.
          ptr_d = ptr_q;
        end
      endcase
    end
    // A new start wins over a done pulse arriving the same cycle.
    // A done pulse with no transfer pending leaves the state idle.
    if (start_d) begin
      dma_d = usb_periph_pkg::DMA_BUSY;
    end else if (dma_done_evt) begin
      dma_d = usb_periph_pkg::DMA_IDLE;
    end
  end

  // Sticky status: a set arriving with its clear still lands. Mask writes
  // never reach this path.
  // Bit 7 is a live DMA view, so it is never stored here.
  always_comb begin
    status_d = (status_q & ~clear_mask) | events;
    status_d[usb_periph_pkg::IRQ_DMA_ACTIVE] = 1'b0;
  end

  // Register file and DMA state, all cleared at reset.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pins_p_q <= usb_periph_pkg::PINS_IDLE;
      ptr_q <= usb_periph_pkg::RST_BYTE;
      ctrl_q <= usb_periph_pkg::RST_XFER_CTRL;
      mask_q <= usb_periph_pkg::RST_IRQ_MASK;
      addr_q <= usb_periph_pkg::RST_DEV_ADDR;
      status_q <= usb_periph_pkg::RST_IRQ_STATUS;
      cnt_lo_q <= usb_periph_pkg::RST_BYTE;
      cnt_hi_q <= usb_periph_pkg::RST_BYTE;
      dma_q <= usb_periph_pkg::DMA_IDLE;
    end else if (clk_en) begin
      pins_p_q <= pins_p_d;
      ptr_q <= ptr_d;
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      addr_q <= addr_d;
      status_q <= status_d;
      cnt_lo_q <= cnt_lo_d;
      cnt_hi_q <= cnt_hi_d;
      dma_q <= dma_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output decode.
  logic [7:0] rdata_d;
  logic oe_d;
  logic standby_d, suspend_d, speed_d;
  logic force_oe_d, dp_d, dm_d;
  logic usb_en_d, dir_d, dma_en_d, active_d, irq_d, accept_d;
  usb_periph_pkg::line_force_e force_code;
  logic dma_busy;

  // Force code gathered from the two control bits.
  assign force_code = usb_periph_pkg::line_force_e'(
    {ctrl_q[usb_periph_pkg::CTL_FORCE_HI],
     ctrl_q[usb_periph_pkg::CTL_FORCE_LO]});

  // Stored DMA state as a plain flag for the read mux.
  assign dma_busy = dma_q == usb_periph_pkg::DMA_BUSY;

  // Read mux; the mask register's top bit shows DMA activity.
  always_comb begin
    unique case (ptr_q)
      usb_periph_pkg::OFS_XFER_CTRL: rdata_d = ctrl_q;
      usb_periph_pkg::OFS_IRQ_MASK: begin
        rdata_d = {dma_busy, mask_q[6:0]};
      end
      usb_periph_pkg::OFS_DEV_ADDR: rdata_d = addr_q;
      usb_periph_pkg::OFS_IRQ_STATUS: begin
        rdata_d = {dma_busy, status_q[6:0]};
      end
      usb_periph_pkg::OFS_DMA_CNT_LO: rdata_d = cnt_lo_q;
      usb_periph_pkg::OFS_DMA_CNT_HI: rdata_d = cnt_hi_q;
      default: rdata_d = usb_periph_pkg::RST_BYTE;
    endcase
    oe_d = reading;
  end

  // Bus line forcing, decoded from the two force bits.
  always_comb begin
    force_oe_d = 1'b1;
    dp_d = 1'b0;
    dm_d = 1'b0;
    unique case (force_code)
      usb_periph_pkg::FORCE_NONE: force_oe_d = 1'b0;
      usb_periph_pkg::FORCE_SE0: begin
        dp_d = 1'b0;
        dm_d = 1'b0;
      end
      usb_periph_pkg::FORCE_K: dm_d = 1'b1;
      usb_periph_pkg::FORCE_J: dp_d = 1'b1;
    endcase
  end

  // Control levels, interrupt and address match.
  always_comb begin
    standby_d = ctrl_q[usb_periph_pkg::CTL_STANDBY];
    usb_en_d = ctrl_q[usb_periph_pkg::CTL_USB_EN];
    suspend_d = standby_d && !usb_en_d;
    speed_d = ctrl_q[usb_periph_pkg::CTL_SPEED];
    dir_d = ctrl_q[usb_periph_pkg::CTL_DMA_DIR];
    dma_en_d = ctrl_q[usb_periph_pkg::CTL_DMA_EN];
    active_d = dma_d == usb_periph_pkg::DMA_BUSY;
    // Each status bit drives the output only through its enable bit; bit 6
    // bus reset, bit 5 frame start, bit 4 DMA done, bits 3:0 endpoints.
    irq_d = |(status_d[6:0] &
              mask_d[6:0]);
    // Status bit 7 is never stored, so DMA activity raises no interrupt.
    // A disabled device accepts no token at all.
    // Address bit 7 is compared too, so a value above 7F never matches.
    accept_d = token_valid && usb_en_d &&
               ({1'b0, token_addr} == addr_q);
  end

  // Every output comes from a flop so pins never see decode glitches.
  // The price is one cycle of latency on each level decoded from ctrl_q; DMA activity and count come from next values.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_out <= usb_periph_pkg::RST_BYTE;
      data_oe <= 1'b0;
      bus_transceiver_low_power <= 1'b0;
      suspend <= 1'b0;
      bus_speed_select <= 1'b0;
      line_force_oe <= 1'b0;
      line_dp <= 1'b0;
      line_dm <= 1'b0;
      usb_enable <= 1'b0;
      dma_read_dir <= 1'b0;
      dma_enable <= 1'b0;
      dma_start <= 1'b0;
      dma_active <= 1'b0;
      dma_total_count <= 16'h0000;
      interrupt_request_out <= 1'b0;
      token_accept <= 1'b0;
    end else if (clk_en) begin
      data_out <= rdata_d;
      data_oe <= oe_d;
      bus_transceiver_low_power <= standby_d;
      suspend <= suspend_d;
      bus_speed_select <= speed_d;
      line_force_oe <= force_oe_d;
      line_dp <= dp_d;
      line_dm <= dm_d;
      usb_enable <= usb_en_d;
      dma_read_dir <= dir_d;
      dma_enable <= dma_en_d;
      dma_start <= start_d;
      dma_active <= active_d;
      dma_total_count <= {cnt_hi_d, cnt_lo_d};
      interrupt_request_out <= irq_d;
      token_accept <= accept_d;
    end
  end

endmodule
`default_nettype wire

// *** usb_periph_pkg.sv ***
// Behaviour
// - Standby bit 6 set puts the bus transceiver in low power.
// - Suspend holds exactly while standby is one and USB enable is zero.
// - Speed bit 5 zero selects full speed, one selects low speed.
// - Line-force bits 4:3: 00 normal, 01 SE0, 10 K state, 11 J state.
// - Both line-force bits clear at power-up so the bus starts normal.
// - DMA direction bit 2 one reads out of device, zero writes in.
// - DMA enable bit 1 permits DMA when one, forbids when zero.
// - DMA starts only on the high count byte write, while enabled.
// - USB enable bit 0 gates token acceptance, not DMA starts, and resets to zero.
// - Interrupt output asserts only for events whose enable bit is one.
// - Writing the enable register never changes interrupt status.
// - Enable bit 6 unmasks the bus reset received interrupt.
// - Enable bit 5 unmasks the start-of-frame received interrupt.
// - Enable bit 4 unmasks the DMA done interrupt.
// - Enable bits 3 to 0 unmask the matching endpoint done interrupt.
// - Device address register is 8 bits, cleared at reset.
// - Device answers only transactions matching the address register.
// - Status bits clear on written ones; output is OR of masked status.
package usb_periph_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register offsets seen through the indexed data port.
  localparam logic [7:0] OFS_XFER_CTRL = 8'h05;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h06;
  localparam logic [7:0] OFS_DEV_ADDR = 8'h07;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0D;
  localparam logic [7:0] OFS_DMA_CNT_LO = 8'h35;
  localparam logic [7:0] OFS_DMA_CNT_HI = 8'h36;

  //////////////////////////////////////////////////////////////////////////
  // Transfer control field positions.
  localparam int CTL_RSVD = 7;
  localparam int CTL_STANDBY = 6;
  localparam int CTL_SPEED = 5;
  localparam int CTL_FORCE_HI = 4;
  localparam int CTL_FORCE_LO = 3;
  localparam int CTL_DMA_DIR = 2;
  localparam int CTL_DMA_EN = 1;
  localparam int CTL_USB_EN = 0;

  // Interrupt enable and status field positions.
  localparam int IRQ_DMA_ACTIVE = 7;
  localparam int IRQ_BUS_RESET = 6;
  localparam int IRQ_SOF = 5;
  localparam int IRQ_DMA_DONE = 4;
  localparam int IRQ_EP_TOP = 3;
  localparam int NUM_EP = 4;

  // Reset values.
  localparam logic [7:0] RST_XFER_CTRL = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic [7:0] RST_DEV_ADDR = 8'h00;
  localparam logic [7:0] RST_IRQ_STATUS = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Synchroniser depth for pin inputs.
  localparam int SYNC_STAGES = 2;

  //////////////////////////////////////////////////////////////////////////
  // Processor port pins, bundled so they cross the synchroniser together.
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic a0;
    logic [7:0] data;
  } cpu_pins_s;

  localparam cpu_pins_s PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                      a0: 1'b0, data: 8'h00};

  // Line-force codes.
  typedef enum logic [1:0] {
    FORCE_NONE = 2'b00,
    FORCE_SE0 = 2'b01,
    FORCE_K = 2'b10,
    FORCE_J = 2'b11
  } line_force_e;

  // DMA activity.
  typedef enum logic {
    DMA_IDLE = 1'b0,
    DMA_BUSY = 1'b1
  } dma_state_e;

endpackage
